/* hw/conq_pkg.sv */
`default_nettype none
package conq_pkg;
   localparam int SLOT_W = 13;
   localparam int SIZE_W = 8;
   localparam int UNIT_SHIFT = 5;
   localparam int SLOT_BYTES = 2048;
   localparam int SDRAM_SLOTS = 8192;
   localparam logic [8:0] MAX_UNITS = 9'(SDRAM_SLOTS >> UNIT_SHIFT);
   localparam int NREQ = 4;
   // Requester indices; bit 1 picks the queue, bit 0 set means dequeue
   localparam int REQ_MAC_RX_ENQ = 0;
   localparam int REQ_HDLC_RX_DEQ = 1;
   localparam int REQ_HDLC_TX_ENQ = 2;
   localparam int REQ_MAC_TX_DEQ = 3;
   localparam int Q_RX = 0;
   localparam int Q_TX = 1;
   // Register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_TX_SIZE = 8'h04;
   localparam logic [7:0] OFS_RX_SIZE = 8'h08;
   localparam logic [7:0] OFS_TX_HIGH = 8'h0c;
   localparam logic [7:0] OFS_TX_LOW = 8'h10;
   localparam logic [7:0] OFS_RX_HIGH = 8'h14;
   localparam logic [7:0] OFS_RX_LOW = 8'h18;
   localparam logic [7:0] OFS_IRQ_EN = 8'h1c;
   localparam logic [7:0] OFS_TX_STAT = 8'h20;
   localparam logic [7:0] OFS_RX_STAT = 8'h24;
   localparam logic [7:0] OFS_GLB_STAT = 8'h28;
   localparam logic [7:0] OFS_LEVEL = 8'h2c;
   // Field positions
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_PRST_BIT = 1;
   localparam int ST_HIGH_BIT = 0;
   localparam int ST_LOW_BIT = 1;
   localparam int IEN_TX_LSB = 0;
   localparam int IEN_RX_LSB = 2;
   localparam int IEN_GLB_BIT = 4;
   localparam int GST_CONN_BIT = 2;
   localparam int LVL_RX_LSB = 0;
   localparam int LVL_TX_LSB = 16;
   // Reset values
   localparam logic [SIZE_W-1:0] SIZE_RST = 8'h01;
   localparam logic [SLOT_W-1:0] HIGH_RST = 13'h0018;
   localparam logic [SLOT_W-1:0] LOW_RST = 13'h0008;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] HRESP_OKAY = 2'h0;
   typedef enum logic [0:0] {ARB_IDLE, ARB_WAIT} arb_state_type;
endpackage
`default_nettype wire

/* hw/conq_if.sv */
`default_nettype none
interface conq_if;
   import conq_pkg::*;
   logic connection_enable;
   logic queue_pointer_reset;
   logic [SIZE_W-1:0] tx_queue_size;
   logic [SIZE_W-1:0] rx_queue_size;
   logic [SLOT_W-1:0] tx_base;
   logic [SLOT_W-1:0] rx_base;
   logic [SLOT_W-1:0] tx_high;
   logic [SLOT_W-1:0] tx_low;
   logic [SLOT_W-1:0] rx_high;
   logic [SLOT_W-1:0] rx_low;
   logic [1:0] tx_threshold_irq_enable;
   logic [1:0] rx_threshold_irq_enable;
   logic global_queue_irq_enable;
   logic tx_status_read;
   logic rx_status_read;
   logic [1:0] tx_threshold_latched_status;
   logic [1:0] rx_threshold_latched_status;
   logic [1:0] global_queue_irq_status;
   logic queue_irq;
   logic [SLOT_W-1:0] tx_level;
   logic [SLOT_W-1:0] rx_level;
   logic [NREQ-1:0] eng_req;
   logic [NREQ-1:0] eng_grant;
   modport dev (
      input connection_enable, queue_pointer_reset, tx_queue_size,
      input rx_queue_size, tx_base, rx_base, tx_high, tx_low, rx_high,
      input rx_low, tx_threshold_irq_enable, rx_threshold_irq_enable,
      input global_queue_irq_enable, tx_status_read, rx_status_read,
      input eng_req,
      output tx_threshold_latched_status, rx_threshold_latched_status,
      output global_queue_irq_status, queue_irq, tx_level, rx_level,
      output eng_grant
   );
   modport ctl (
      output connection_enable, queue_pointer_reset, tx_queue_size,
      output rx_queue_size, tx_base, rx_base, tx_high, tx_low, rx_high,
      output rx_low, tx_threshold_irq_enable, rx_threshold_irq_enable,
      output global_queue_irq_enable, tx_status_read, rx_status_read,
      output eng_req,
      input tx_threshold_latched_status, rx_threshold_latched_status,
      input global_queue_irq_status, queue_irq, tx_level, rx_level,
      input eng_grant
   );
endinterface
`default_nettype wire

/* hw/queue_ring.sv */
`default_nettype none
module queue_ring
   import conq_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [SIZE_W-1:0] size_units,
   input wire logic [SLOT_W-1:0] base,
   input wire logic [SLOT_W-1:0] high,
   input wire logic [SLOT_W-1:0] low,
   input wire logic push,
   input wire logic pop,
   input wire logic ptr_reset,
   input wire logic flush,
   output logic [SLOT_W-1:0] wr_addr,
   output logic [SLOT_W-1:0] rd_addr,
   output logic [SLOT_W-1:0] level,
   output logic full,
   output logic empty,
   output logic high_evt,
   output logic low_evt
);
   logic [SLOT_W-1:0] wr_off_r;
   logic [SLOT_W-1:0] rd_off_r;
   logic [SLOT_W-1:0] level_r;
   logic [SLOT_W-1:0] level_nxt;
   logic [SLOT_W-1:0] cap;
   logic do_push;
   logic do_pop;

   assign cap = {size_units, 5'h00}; // [R2]
   assign full = (level_r >= cap);
   assign empty = (level_r == 13'h0000);
   assign do_push = push & ~full;
   assign do_pop = pop & ~empty;
   assign wr_addr = SLOT_W'(base + wr_off_r); // [R21]
   assign rd_addr = SLOT_W'(base + rd_off_r); // [R21]
   assign level = level_r;

   always_comb
   begin
      level_nxt = level_r;
      if (do_push & ~do_pop)
         level_nxt = SLOT_W'(level_r + 13'h0001);
      else if (do_pop & ~do_push)
         level_nxt = SLOT_W'(level_r - 13'h0001);
   end

   // Watermark crossings, suppressed on reset or flush
   assign high_evt = ~ptr_reset & ~flush & (level_r <= high)
      & (level_nxt > high); // [R10]
   assign low_evt = ~ptr_reset & ~flush & (level_r > low)
      & (level_nxt <= low); // [R11]

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_off_r <= 13'h0000;
         rd_off_r <= 13'h0000;
      end
      else if (ptr_reset)
      begin
         wr_off_r <= 13'h0000; // [R21]
         rd_off_r <= 13'h0000;
      end
      else if (flush)
         rd_off_r <= wr_off_r; // [R8]
      else
      begin
         if (do_push)
            wr_off_r <= (wr_off_r >= SLOT_W'(cap - 13'h0001)) ? 13'h0000
               : SLOT_W'(wr_off_r + 13'h0001); // [R21]
         if (do_pop)
            rd_off_r <= (rd_off_r >= SLOT_W'(cap - 13'h0001)) ? 13'h0000
               : SLOT_W'(rd_off_r + 13'h0001); // [R21]
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         level_r <= 13'h0000;
      else if (ptr_reset | flush)
         level_r <= 13'h0000; // [R8] [R21]
      else
         level_r <= level_nxt;
   end
endmodule
`default_nettype wire

/* hw/conq_device.sv */
// How it works
// (R1) Receive queue carries Ethernet to WAN
// (R2) Queue size set in 32-slot units
// (R3) Host keeps total within 8192 slots
// (R4) Host keeps queue regions apart
// (R5) Overlap goes undetected, no error flag
// (R6) One enable covers both queues together
// (R7) Host disconnects before resizing queues
// (R8) Disconnect flushes queues, drives ones
// (R9) HDLC clocks held low while disconnected
// (R10) High crossing latches status, enable gates irq
// (R11) Low crossing latches its own status
// (R12) Status read clears its latched bits
// (R13) Receive queue mirrors transmit queue controls
// (R14) Global enable and status gather queue events
// (R15) Host never programs size zero
// (R16) Host resets pointers around connecting
// (R17) Host follows sizes, thresholds, reset, enable
// (R18) Enable links Ethernet to serial side
// (R19) Arbiter performs all SDRAM queue transfers
// (R20) Disabled enable still lets status latch
// (R21) Pointers wrap in region, reset empties
//
// Local design decisions: the AHB-Lite interface to the registers and the address map.
`default_nettype none
module conq_device
   import conq_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   conq_if.dev link,
   output logic sdram_req,
   output logic sdram_write,
   output logic [SLOT_W-1:0] sdram_slot,
   input wire logic sdram_ack,
   input wire logic hdlc_txd,
   output logic ser_txd,
   input wire logic ser_rxd,
   output logic hdlc_rxd,
   input wire logic ser_tclk,
   input wire logic ser_rclk,
   output logic hdlc_tclk,
   output logic hdlc_rclk
);
   arb_state_type state_r;
   logic conn_r;
   logic flush;
   logic [1:0] rr_r;
   logic [1:0] cur_r;
   logic [1:0] sel;
   logic found;
   logic [NREQ-1:0] elig;
   logic [NREQ-1:0] grant_r;
   logic [SLOT_W-1:0] wr_addr [2];
   logic [SLOT_W-1:0] rd_addr [2];
   logic [SLOT_W-1:0] level [2];
   logic [SIZE_W-1:0] qsize [2];
   logic [SLOT_W-1:0] qbase [2];
   logic [SLOT_W-1:0] qhigh [2];
   logic [SLOT_W-1:0] qlow [2];
   logic [1:0] qen [2];
   logic [1:0] lat_r [2];
   logic [1:0] qread;
   logic [1:0] full;
   logic [1:0] empty;
   logic [1:0] high_evt;
   logic [1:0] low_evt;
   logic [1:0] push;
   logic [1:0] pop;
   logic [1:0] qirq;
   logic done;
   logic irq_r;

   function automatic logic is_deq(input logic [1:0] idx);
      return idx[0];
   endfunction

   function automatic logic q_of(input logic [1:0] idx);
      return idx[1];
   endfunction

   // Receive queue is index 0 (MAC in, HDLC out); transmit is 1
   assign qsize[Q_RX] = link.rx_queue_size; // [R1] [R13]
   assign qsize[Q_TX] = link.tx_queue_size;
   assign qbase[Q_RX] = link.rx_base;
   assign qbase[Q_TX] = link.tx_base;
   assign qhigh[Q_RX] = link.rx_high;
   assign qhigh[Q_TX] = link.tx_high;
   assign qlow[Q_RX] = link.rx_low;
   assign qlow[Q_TX] = link.tx_low;
   assign qen[Q_RX] = link.rx_threshold_irq_enable;
   assign qen[Q_TX] = link.tx_threshold_irq_enable;
   assign qread[Q_RX] = link.rx_status_read;
   assign qread[Q_TX] = link.tx_status_read;

   // Falling enable flushes both directions at once
   assign flush = conn_r & ~link.connection_enable; // [R6] [R8]

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         conn_r <= 1'b0;
      else
         conn_r <= link.connection_enable;
   end

   // Connected only; a request is not retaken in its own grant cycle
   always_comb
   begin
      for (int i = 0; i < NREQ; i++)
         elig[i] = link.eng_req[i] & ~grant_r[i] & link.connection_enable
            & (is_deq(2'(i)) ? ~empty[q_of(2'(i))]
            : ~full[q_of(2'(i))]); // [R18]
   end

   always_comb
   begin
      logic [1:0] idx;
      idx = 2'h0;
      found = 1'b0;
      sel = 2'h0;
      for (int k = 0; k < NREQ; k++)
      begin
         idx = 2'(rr_r + 2'(k));
         if (!found && elig[idx])
         begin
            found = 1'b1;
            sel = idx;
         end
      end
   end

   assign done = (state_r == ARB_WAIT) & sdram_ack;

   always_comb
   begin
      push = 2'b00;
      pop = 2'b00;
      if (done)
      begin
         if (is_deq(cur_r))
            pop[q_of(cur_r)] = 1'b1; // [R19]
         else
            push[q_of(cur_r)] = 1'b1; // [R19]
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         state_r <= ARB_IDLE;
         sdram_req <= 1'b0;
         sdram_write <= 1'b0;
         sdram_slot <= 13'h0000;
         cur_r <= 2'h0;
         rr_r <= 2'h0;
      end
      else
      begin
         unique case (state_r)
            ARB_IDLE:
               if (found)
               begin
                  sdram_req <= 1'b1; // [R19]
                  sdram_write <= ~is_deq(sel);
                  sdram_slot <= is_deq(sel) ? rd_addr[q_of(sel)]
                     : wr_addr[q_of(sel)];
                  cur_r <= sel;
                  state_r <= ARB_WAIT;
               end
            ARB_WAIT:
               if (sdram_ack)
               begin
                  sdram_req <= 1'b0;
                  sdram_write <= 1'b0;
                  rr_r <= 2'(cur_r + 2'h1);
                  state_r <= ARB_IDLE;
               end
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         grant_r <= 4'h0;
      else
         grant_r <= done ? 4'(4'h1 << cur_r) : 4'h0;
   end

   assign link.eng_grant = grant_r;

   // Both queues share SDRAM; overlap is neither checked nor flagged
   genvar q;
   generate
      for (q = 0; q < 2; q++)
      begin : g_q
         queue_ring u_ring (
            .hclk(hclk),
            .hresetn(hresetn),
            .size_units(qsize[q]),
            .base(qbase[q]), // [R5]
            .high(qhigh[q]),
            .low(qlow[q]),
            .push(push[q]),
            .pop(pop[q]),
            .ptr_reset(link.queue_pointer_reset), // [R21]
            .flush(flush),
            .wr_addr(wr_addr[q]),
            .rd_addr(rd_addr[q]),
            .level(level[q]),
            .full(full[q]),
            .empty(empty[q]),
            .high_evt(high_evt[q]),
            .low_evt(low_evt[q])
         );

         // Set wins over the read-clear; enables do not gate latching
         always_ff @(posedge hclk or negedge hresetn)
         begin
            if (!hresetn)
               lat_r[q] <= 2'b00;
            else
            begin
               lat_r[q][ST_HIGH_BIT] <= high_evt[q]
                  | (lat_r[q][ST_HIGH_BIT] & ~qread[q]); // [R10] [R12] [R20]
               lat_r[q][ST_LOW_BIT] <= low_evt[q]
                  | (lat_r[q][ST_LOW_BIT] & ~qread[q]); // [R11] [R12] [R20]
            end
         end

         assign qirq[q] = |(lat_r[q] & qen[q]); // [R10] [R13]
      end
   endgenerate

   assign link.tx_threshold_latched_status = lat_r[Q_TX];
   assign link.rx_threshold_latched_status = lat_r[Q_RX]; // [R13]
   assign link.global_queue_irq_status = {qirq[Q_TX], qirq[Q_RX]}; // [R14]
   assign link.tx_level = level[Q_TX];
   assign link.rx_level = level[Q_RX];

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         irq_r <= 1'b0;
      else
         irq_r <= link.global_queue_irq_enable & (|qirq); // [R14]
   end

   assign link.queue_irq = irq_r;

   // Serial side: idle ones and stopped clocks while disconnected
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ser_txd <= 1'b1;
         hdlc_rxd <= 1'b1;
         hdlc_tclk <= 1'b0;
         hdlc_rclk <= 1'b0;
      end
      else
      begin
         ser_txd <= link.connection_enable ? hdlc_txd : 1'b1; // [R8] [R18]
         hdlc_rxd <= link.connection_enable ? ser_rxd : 1'b1; // [R8]
         hdlc_tclk <= link.connection_enable & ser_tclk; // [R9]
         hdlc_rclk <= link.connection_enable & ser_rclk; // [R9]
      end
   end
endmodule
`default_nettype wire

/* hw/conq_ctl.sv */
`default_nettype none
module conq_ctl
   import conq_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [1:0] hresp,
   output logic [31:0] hrdata,
   input wire logic [NREQ-1:0] eng_req,
   output logic [NREQ-1:0] eng_grant,
   output logic irq,
   conq_if.ctl link
);
   logic dp_r;
   logic dp_wr_r;
   logic [7:0] dp_addr_r;
   logic en_r;
   logic prst_r;
   logic [SIZE_W-1:0] tx_size_r;
   logic [SIZE_W-1:0] rx_size_r;
   logic [SLOT_W-1:0] tx_high_r;
   logic [SLOT_W-1:0] tx_low_r;
   logic [SLOT_W-1:0] rx_high_r;
   logic [SLOT_W-1:0] rx_low_r;
   logic [4:0] ien_r;
   logic wr;
   logic rd;
   logic [SIZE_W-1:0] wsize;
   logic size_ok_tx;
   logic size_ok_rx;

   assign hreadyout = 1'b1;
   assign hresp = HRESP_OKAY;
   assign wr = dp_r & dp_wr_r;
   assign rd = dp_r & ~dp_wr_r;
   assign wsize = hwdata[SIZE_W-1:0];
   // Nonzero, disconnected, and total within SDRAM
   assign size_ok_tx = ~en_r & (wsize != 8'h00)
      & ({1'b0, wsize} + {1'b0, rx_size_r} <= MAX_UNITS); // [R3] [R7] [R15]
   assign size_ok_rx = ~en_r & (wsize != 8'h00)
      & ({1'b0, wsize} + {1'b0, tx_size_r} <= MAX_UNITS); // [R3] [R7] [R15]

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         dp_r <= 1'b0;
         dp_wr_r <= 1'b0;
         dp_addr_r <= 8'h00;
      end
      else if (hready)
      begin
         dp_r <= hsel & (htrans == HTRANS_NONSEQ);
         dp_wr_r <= hwrite;
         dp_addr_r <= haddr[7:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         en_r <= 1'b0;
         prst_r <= 1'b0;
      end
      else
      begin
         prst_r <= 1'b0;
         if (wr && dp_addr_r == OFS_CTRL)
         begin
            en_r <= hwdata[CTRL_EN_BIT]; // [R17]
            // Pointer reset on request and on any change of connection
            prst_r <= hwdata[CTRL_PRST_BIT]
               | (hwdata[CTRL_EN_BIT] != en_r); // [R16]
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         tx_size_r <= SIZE_RST;
         rx_size_r <= SIZE_RST;
      end
      else if (wr)
      begin
         if (dp_addr_r == OFS_TX_SIZE && size_ok_tx)
            tx_size_r <= wsize;
         if (dp_addr_r == OFS_RX_SIZE && size_ok_rx)
            rx_size_r <= wsize;
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         tx_high_r <= HIGH_RST;
         tx_low_r <= LOW_RST;
         rx_high_r <= HIGH_RST;
         rx_low_r <= LOW_RST;
         ien_r <= 5'h00;
      end
      else if (wr)
      begin
         unique case (dp_addr_r)
            OFS_TX_HIGH: tx_high_r <= hwdata[SLOT_W-1:0];
            OFS_TX_LOW: tx_low_r <= hwdata[SLOT_W-1:0];
            OFS_RX_HIGH: rx_high_r <= hwdata[SLOT_W-1:0];
            OFS_RX_LOW: rx_low_r <= hwdata[SLOT_W-1:0];
            OFS_IRQ_EN: ien_r <= hwdata[4:0];
            default: ;
         endcase
      end
   end

   always_comb
   begin
      hrdata = 32'h0000_0000;
      if (rd)
      begin
         unique case (dp_addr_r)
            OFS_CTRL: hrdata[CTRL_EN_BIT] = en_r;
            OFS_TX_SIZE: hrdata[SIZE_W-1:0] = tx_size_r;
            OFS_RX_SIZE: hrdata[SIZE_W-1:0] = rx_size_r;
            OFS_TX_HIGH: hrdata[SLOT_W-1:0] = tx_high_r;
            OFS_TX_LOW: hrdata[SLOT_W-1:0] = tx_low_r;
            OFS_RX_HIGH: hrdata[SLOT_W-1:0] = rx_high_r;
            OFS_RX_LOW: hrdata[SLOT_W-1:0] = rx_low_r;
            OFS_IRQ_EN: hrdata[4:0] = ien_r;
            OFS_TX_STAT: hrdata[1:0] = link.tx_threshold_latched_status;
            OFS_RX_STAT: hrdata[1:0] = link.rx_threshold_latched_status;
            OFS_GLB_STAT:
            begin
               hrdata[1:0] = link.global_queue_irq_status;
               hrdata[GST_CONN_BIT] = en_r;
            end
            OFS_LEVEL:
            begin
               hrdata[LVL_RX_LSB +: SLOT_W] = link.rx_level;
               hrdata[LVL_TX_LSB +: SLOT_W] = link.tx_level;
            end
            default: hrdata = 32'h0000_0000;
         endcase
      end
   end

   assign link.connection_enable = en_r;
   assign link.queue_pointer_reset = prst_r;
   assign link.tx_queue_size = tx_size_r;
   assign link.rx_queue_size = rx_size_r;
   // Transmit region first, receive region right after it
   assign link.tx_base = 13'h0000; // [R4]
   assign link.rx_base = {tx_size_r, 5'h00}; // [R4]
   assign link.tx_high = tx_high_r;
   assign link.tx_low = tx_low_r;
   assign link.rx_high = rx_high_r;
   assign link.rx_low = rx_low_r;
   assign link.tx_threshold_irq_enable = ien_r[IEN_TX_LSB +: 2];
   assign link.rx_threshold_irq_enable = ien_r[IEN_RX_LSB +: 2];
   assign link.global_queue_irq_enable = ien_r[IEN_GLB_BIT];
   assign link.tx_status_read = rd & (dp_addr_r == OFS_TX_STAT);
   assign link.rx_status_read = rd & (dp_addr_r == OFS_RX_STAT);
   assign link.eng_req = eng_req;
   assign eng_grant = link.eng_grant;
   assign irq = link.queue_irq;
endmodule
`default_nettype wire

/* dv/conq_chk.sv */
`default_nettype none
module conq_chk
   import conq_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic connection_enable,
   input wire logic queue_pointer_reset,
   input wire logic [SLOT_W-1:0] tx_level,
   input wire logic [SLOT_W-1:0] rx_level,
   input wire logic [SLOT_W-1:0] rx_high,
   input wire logic [SLOT_W-1:0] tx_low,
   input wire logic [1:0] tx_threshold_latched_status,
   input wire logic [1:0] rx_threshold_latched_status,
   input wire logic [1:0] tx_threshold_irq_enable,
   input wire logic [1:0] global_queue_irq_status,
   input wire logic tx_status_read,
   input wire logic [NREQ-1:0] eng_req,
   input wire logic [NREQ-1:0] eng_grant
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   flush_levels_a: assert property (
      $fell(connection_enable) |-> ##[1:2] (tx_level == 0 && rx_level == 0))
      else $error("queues not flushed");
   ptr_reset_a: assert property (
      queue_pointer_reset |-> ##[1:2] (tx_level == 0 && rx_level == 0))
      else $error("pointer reset left data");
   grant_onehot_a: assert property (
      $onehot0(eng_grant))
      else $error("two grants at once");
   grant_spacing_a: assert property (
      eng_grant != 0 |=> eng_grant == 0 [*2])
      else $error("grants too close");
   grant_req_a: assert property (
      eng_grant != 0 |-> (eng_grant & ~eng_req) == 0)
      else $error("grant without request");
   rx_enqueue_a: assert property (
      eng_grant[REQ_MAC_RX_ENQ] |-> rx_level == $past(rx_level) + 13'h1)
      else $error("rx level not raised");
   tx_dequeue_a: assert property (
      eng_grant[REQ_MAC_TX_DEQ] |-> tx_level == $past(tx_level) - 13'h1)
      else $error("tx level not lowered");
   rx_high_a: assert property (
      eng_grant != 0 && $past(rx_level) <= rx_high && rx_level > rx_high
      |-> ##[0:1] rx_threshold_latched_status[ST_HIGH_BIT])
      else $error("rx high crossing not latched");
   tx_low_a: assert property (
      eng_grant != 0 && $past(tx_level) > tx_low && tx_level <= tx_low
      |-> ##[0:1] tx_threshold_latched_status[ST_LOW_BIT])
      else $error("tx low crossing not latched");
   tx_clear_a: assert property (
      tx_status_read && eng_grant == 0 && $past(eng_grant) == 0
      |=> tx_threshold_latched_status == 2'h0)
      else $error("tx status not cleared by read");
   glb_tx_a: assert property (
      global_queue_irq_status[Q_TX] ==
      |(tx_threshold_latched_status & tx_threshold_irq_enable))
      else $error("global tx status wrong");
endmodule
`default_nettype wire

/* dv/tb.sv */
`default_nettype none
module tb
   import conq_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic hclk, hresetn, hsel, hwrite, hreadyout, irq, sreq, swr, sack, wcap;
   logic [31:0] haddr, hwdata, hrdata, q;
   logic [1:0] htrans, hresp;
   logic [NREQ-1:0] eng_req, eng_grant;
   logic [3:0] sin, s1;
   logic [2:0] enh;
   logic [SLOT_W-1:0] slot, scap;
   wire logic [3:0] sout;
   logic [7:0] ra[5] = '{OFS_CTRL, OFS_TX_SIZE, OFS_RX_HIGH, OFS_TX_LOW, 8'h40};
   logic [31:0] rv[5] = '{32'h0, SIZE_RST, HIGH_RST, LOW_RST, 32'h0};
   int seed = 32'h6ef3;
   int mismatches, num_checks, rl, tl, rsz, wo[2], ro[2];
   bit con;
   conq_if lk();
   conq_ctl i_conq_ctl(.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
      .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
      .eng_req, .eng_grant, .irq, .link(lk.ctl));
   conq_device i_conq_device(.hclk, .hresetn, .link(lk.dev), .sdram_req(sreq),
      .sdram_write(swr), .sdram_slot(slot), .sdram_ack(sack), .hdlc_txd(sin[3]),
      .ser_txd(sout[3]), .ser_rxd(sin[2]), .hdlc_rxd(sout[2]),
      .ser_tclk(sin[1]), .ser_rclk(sin[0]), .hdlc_tclk(sout[1]),
      .hdlc_rclk(sout[0]));
   conq_chk i_conq_chk(.hclk, .hresetn,
      .connection_enable(lk.connection_enable),
      .queue_pointer_reset(lk.queue_pointer_reset),
      .tx_level(lk.tx_level), .rx_level(lk.rx_level), .rx_high(lk.rx_high),
      .tx_low(lk.tx_low),
      .tx_threshold_latched_status(lk.tx_threshold_latched_status),
      .rx_threshold_latched_status(lk.rx_threshold_latched_status),
      .tx_threshold_irq_enable(lk.tx_threshold_irq_enable),
      .global_queue_irq_status(lk.global_queue_irq_status),
      .tx_status_read(lk.tx_status_read), .eng_req(lk.eng_req),
      .eng_grant(lk.eng_grant));
   task chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task results;
      if (mismatches == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task bail;
      mismatches++;
      results;
   endtask
   task hw(inout int n);
      do @(posedge hclk);
      while (hreadyout !== 1'b1 && ++n < 99);
      if (n >= 99)
         bail;
   endtask
   task ahb(input logic [7:0] a, input logic w, input logic [31:0] d);
      int n;
      n = 0;
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= HTRANS_NONSEQ;
      hw(n);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      hw(n);
      q = hrdata;
   endtask
   task rc(input logic [7:0] a, input logic [31:0] e);
      ahb(a, 1'b0, 32'h0);
      chk(q, e);
   endtask
   // Served only if connected and queue has room or data
   function bit elig(int i);
      int l;
      l = i[1] ? tl : rl;
      return con && (i[0] ? l > 0 : l < (i[1] ? 1 : rsz) * 32);
   endfunction
   task eng(int i);
      int n, c;
      bit ok;
      ok = elig(i);
      n = 0;
      eng_req[i] <= 1'b1;
      do @(posedge hclk);
      while (eng_grant[i] !== 1'b1 && ++n < 40);
      eng_req[i] <= 1'b0;
      chk(n < 40, ok);
      if (ok && n >= 40)
         bail;
      if (ok)
      begin
         chk(wcap, !i[0]);
         c = (i[1] ? 1 : rsz) * 32;
         chk(scap, (i[1] ? 0 : 32) + (i[0] ? ro[i[1]] : wo[i[1]]));
         if (i[0])
            ro[i[1]] = (ro[i[1]] + 1) % c;
         else
            wo[i[1]] = (wo[i[1]] + 1) % c;
         if (i[1])
            tl += i[0] ? -1 : 1;
         else
            rl += i[0] ? -1 : 1;
      end
      rc(OFS_LEVEL, {3'h0, 13'(tl), 3'h0, 13'(rl)});
   endtask
   initial
   begin
      hclk = 1'b0;
      forever #10 hclk = ~hclk;
   end
   // Random serial lines and randomly slow memory acknowledge
   always @(posedge hclk)
   begin
      sin <= 4'($random(seed));
      sack <= sreq && !sack && ($random(seed) & 1);
      if (sack)
      begin
         wcap <= swr;
         scap <= slot;
      end
   end
   // Skip cycles near a connect or disconnect edge
   always @(negedge hclk)
   begin
      if (hresetn && (enh == 3'h0 || enh == 3'h7))
         chk({28'h0, sout}, enh[0] ? {28'h0, s1} : 32'hc);
      s1 <= sin;
      enh <= {enh[1:0], lk.connection_enable};
   end
   initial
   begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hwdata = 32'h0;
      eng_req = '0;
      sin = 4'h0;
      sack = 1'b0;
      enh = 3'h0;
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      ahb(8'h40, 1'b1, 32'hffffffff);
      for (int k = 0; k < 5; k++)
         rc(ra[k], rv[k]);
      ahb(OFS_TX_SIZE, 1'b1, 32'h0);
      rc(OFS_TX_SIZE, 32'h1);
      ahb(OFS_TX_SIZE, 1'b1, 32'hff);
      ahb(OFS_RX_SIZE, 1'b1, 32'h2);
      rc(OFS_RX_SIZE, 32'h1);
      rc(OFS_TX_SIZE, 32'hff);
      rsz = 1 + ($random(seed) & 3);
      ahb(OFS_TX_SIZE, 1'b1, 32'h1);
      ahb(OFS_RX_SIZE, 1'b1, rsz);
      rc(OFS_RX_SIZE, rsz);
      ahb(OFS_RX_HIGH, 1'b1, 32'h2);
      ahb(OFS_RX_LOW, 1'b1, 32'h1);
      ahb(OFS_TX_HIGH, 1'b1, 32'h1);
      ahb(OFS_TX_LOW, 1'b1, 32'h0);
      ahb(OFS_IRQ_EN, 1'b1, 32'h14);
      ahb(OFS_CTRL, 1'b1, 32'h1);
      con = 1'b1;
      ahb(OFS_TX_SIZE, 1'b1, 32'h2);
      rc(OFS_TX_SIZE, 32'h1);
      repeat (3) eng(REQ_MAC_RX_ENQ);
      rc(OFS_GLB_STAT, 32'h5);
      chk(irq, 1'b1);
      rc(OFS_RX_STAT, 32'h1);
      rc(OFS_RX_STAT, 32'h0);
      chk(irq, 1'b0);
      repeat (2) eng(REQ_HDLC_TX_ENQ);
      rc(OFS_TX_STAT, 32'h1);
      chk(irq, 1'b0);
      repeat (2) eng(REQ_HDLC_RX_DEQ);
      rc(OFS_RX_STAT, 32'h2);
      repeat (2) eng(REQ_MAC_TX_DEQ);
      rc(OFS_TX_STAT, 32'h2);
      eng(REQ_MAC_TX_DEQ);
      repeat (rsz * 32 + 1) eng(REQ_MAC_RX_ENQ);
      repeat (60) eng($random(seed) & 3);
      ahb(OFS_CTRL, 1'b1, 32'h3);
      rl = 0;
      tl = 0;
      wo = '{0, 0};
      ro = '{0, 0};
      rc(OFS_LEVEL, 32'h0);
      rc(OFS_CTRL, 32'h1);
      eng(REQ_HDLC_TX_ENQ);
      ahb(OFS_CTRL, 1'b1, 32'h0);
      con = 1'b0;
      tl = 0;
      rc(OFS_LEVEL, 32'h0);
      eng(REQ_MAC_RX_ENQ);
      results;
   end
endmodule
`default_nettype wire
